// ### inc/cpm_pkg.sv
package cpm_pkg;
	localparam int CLK_MHZ = 100;
	localparam logic [16:0] CORE_KHZ = 17'h186A0;
	localparam logic [16:0] FRO_KHZ_15 = 17'h03A98;
	localparam logic [16:0] FRO_KHZ_12 = 17'h02EE0;
	localparam logic [16:0] FRO_KHZ_9 = 17'h02328;
	localparam int LPOSC_KHZ = 1000;
	localparam logic [6:0] LPOSC_DIV_CYC = 7'(100000 / LPOSC_KHZ);
	localparam int SETTLE_NS = 200;
	localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] FRO_HALF_DIV = 8'h02;

	localparam logic [7:0] FRO_CTRL_OFS = 8'h00;
	localparam logic [7:0] MAIN_SEL_OFS = 8'h04;
	localparam logic [7:0] CPU_DIV_OFS = 8'h08;
	localparam logic [7:0] PERIPH_GATE_OFS = 8'h0C;
	localparam logic [7:0] PDIV0_OFS = 8'h10;
	localparam logic [7:0] PDIV1_OFS = 8'h14;
	localparam logic [7:0] PDIV2_OFS = 8'h18;
	localparam logic [7:0] CLOCK_OUTPUT_FUNCTION_SEL_OFS = 8'h1C;
	localparam logic [7:0] RUN_PWR_OFS = 8'h20;
	localparam logic [7:0] SLEEP_CFG_OFS = 8'h24;
	localparam logic [7:0] WAKE_EN_OFS = 8'h28;
	localparam logic [7:0] STATUS_OFS = 8'h2C;

	localparam logic [1:0] FRO_SEL_15 = 2'h0;
	localparam logic [1:0] FRO_SEL_12 = 2'h1;
	localparam logic [1:0] FRO_SEL_9 = 2'h2;
	localparam int FRO_HALF_BIT = 2;
	localparam logic [2:0] FRO_CTRL_RST = 3'h1;

	localparam logic [2:0] SRC_FRO = 3'h0;
	localparam logic [2:0] SRC_FRO_HALF = 3'h1;
	localparam logic [2:0] SRC_EXT = 3'h2;
	localparam logic [2:0] SRC_LPOSC = 3'h3;
	localparam logic [2:0] OUT_FRO = 3'h0;
	localparam logic [2:0] OUT_LPOSC = 3'h1;
	localparam logic [2:0] OUT_MAIN = 3'h2;
	localparam logic [2:0] OUT_EXT = 3'h3;
	localparam logic [2:0] SRC_NONE = 3'h4;

	localparam logic [7:0] CPU_DIV_RST = 8'h01;
	localparam logic [7:0] PDIV_RST = 8'h01;
	localparam logic [7:0] PERIPH_GATE_RST = 8'h00;
	localparam int NUM_PERIPH = 8;
	localparam int NUM_PDIV = 3;

	localparam int RUN_LPOSC_BIT = 0;
	localparam int RUN_BOD_BIT = 1;
	localparam logic [1:0] RUN_PWR_RST = 2'h2;

	localparam logic [1:0] MODE_SLEEP = 2'h0;
	localparam logic [1:0] MODE_DEEP = 2'h1;
	localparam logic [1:0] MODE_PDOWN = 2'h2;
	localparam int SLP_KEEP_FRO_BIT = 2;
	localparam int SLP_KEEP_LPOSC_BIT = 3;
	localparam int SLP_KEEP_BOD_BIT = 4;
	localparam logic [4:0] SLEEP_CFG_RST = 5'h00;

	localparam int NUM_WAKE = 6;
	localparam logic [5:0] WAKE_EN_RST = 6'h00;
	localparam int ST_FRO_BIT = 4;
	localparam int ST_LPOSC_BIT = 5;
	localparam int ST_BOD_BIT = 6;
	localparam int ST_CAUSE_LSB = 8;

	typedef enum logic [2:0] {
		ST_RUN, ST_SLEEP, ST_DEEP, ST_PDOWN, ST_RESTORE
	} cpm_state_e;
endpackage

// ### logic/cpm_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_clk_div
	import cpm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Source and ratio
	input wire logic src_tick_i,
	input wire logic [7:0] div_i,
	// Divided clock enable
	output logic tick_o
);
	logic [7:0] cnt_reg;

	// A ratio of zero holds the output still
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= 8'h00;
			tick_o <= 1'b0;
		end else if (src_tick_i && div_i != 8'h00) begin
			if (cnt_reg + 8'h01 >= div_i) begin
				cnt_reg <= 8'h00;
				tick_o <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 8'h01;
				tick_o <= 1'b0;
			end
		end else begin
			tick_o <= 1'b0;
		end
	end
endmodule // cpm_clk_div
`default_nettype wire

// ### logic/cpm_clock_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_clock_power_ctrl
	import cpm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Core side
	input wire logic sleep_req_i,
	input wire logic irq_pending_i,
	output logic core_clk_en_o,
	output logic main_clk_en_o,
	// Wake sources
	input wire logic [5:0] wake_irq_i,
	input wire logic [5:0] vector_en_i,
	// External clock pin and clock output function
	input wire logic external_clock_pin_i,
	input wire logic ext_clk_assigned_i,
	output logic clock_output_function_o,
	// Peripheral clocks
	output logic [7:0] periph_clk_en_o,
	output logic lposc_clk_en_o,
	// Power controls
	output logic fro_on_o,
	output logic fro_out_en_o,
	output logic lposc_on_o,
	output logic brownout_detector_on_o,
	output logic analog_on_o,
	output logic flash_on_o,
	output logic flash_standby_o
);
	// Software registers
	logic [2:0] fro_ctrl_reg;
	logic [2:0] main_sel_reg;
	logic [7:0] cpu_div_reg;
	logic [7:0] periph_gate_reg;
	logic [7:0] pdiv_reg [NUM_PDIV];
	logic [2:0] clock_output_function_sel_reg;
	logic [1:0] run_power_config_reg;
	logic [4:0] sleep_cfg_reg;
	logic [5:0] wake_en_reg;
	logic [5:0] wake_cause_reg;

	// Mode sequencer
	cpm_state_e state_reg;
	cpm_state_e state_next;
	logic [7:0] settle_reg;
	logic [5:0] wake_hit;
	logic low_mode;

	// Source ticks
	logic [16:0] fro_acc_reg;
	logic [16:0] fro_sum;
	logic fro_tick_reg;
	logic fro_out;
	logic fro_half_tick;
	logic [6:0] lposc_cnt_reg;
	logic lposc_tick_reg;
	logic ext_q_reg;
	logic ext_tick;
	logic main_tick;
	logic cpu_tick;
	logic clock_output_function_tick;
	logic [NUM_PDIV-1:0] pdiv_tick;

	// Power control next values
	logic fro_on_next;
	logic lposc_on_next;
	logic bod_on_next;

	function automatic logic [16:0] fro_khz(input logic [1:0] sel);
		case (sel)
			FRO_SEL_15: fro_khz = FRO_KHZ_15;
			FRO_SEL_9: fro_khz = FRO_KHZ_9;
			default: fro_khz = FRO_KHZ_12;
		endcase
	endfunction

	// Register writes
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fro_ctrl_reg <= FRO_CTRL_RST;
			main_sel_reg <= SRC_FRO;
			cpu_div_reg <= CPU_DIV_RST;
			periph_gate_reg <= PERIPH_GATE_RST;
			for (int i = 0; i < NUM_PDIV; i++) begin
				pdiv_reg[i] <= PDIV_RST;
			end
			clock_output_function_sel_reg <= SRC_NONE;
			run_power_config_reg <= RUN_PWR_RST;
			sleep_cfg_reg <= SLEEP_CFG_RST;
			wake_en_reg <= WAKE_EN_RST;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				FRO_CTRL_OFS: fro_ctrl_reg <= reg_wdata_i[2:0];
				MAIN_SEL_OFS: main_sel_reg <= reg_wdata_i[2:0];
				CPU_DIV_OFS: cpu_div_reg <= reg_wdata_i[7:0];
				PERIPH_GATE_OFS: periph_gate_reg <= reg_wdata_i[7:0];
				PDIV0_OFS: pdiv_reg[0] <= reg_wdata_i[7:0];
				PDIV1_OFS: pdiv_reg[1] <= reg_wdata_i[7:0];
				PDIV2_OFS: pdiv_reg[2] <= reg_wdata_i[7:0];
				CLOCK_OUTPUT_FUNCTION_SEL_OFS: clock_output_function_sel_reg <= reg_wdata_i[2:0];
				RUN_PWR_OFS: run_power_config_reg <= reg_wdata_i[1:0];
				SLEEP_CFG_OFS: sleep_cfg_reg <= reg_wdata_i[4:0];
				WAKE_EN_OFS: wake_en_reg <= reg_wdata_i[5:0];
				default: ;
			endcase
		end
	end

	// Register reads, data stand for one cycle only
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= 32'h00000000;
			case (reg_addr_i)
				FRO_CTRL_OFS: reg_rdata_o[2:0] <= fro_ctrl_reg;
				MAIN_SEL_OFS: reg_rdata_o[2:0] <= main_sel_reg;
				CPU_DIV_OFS: reg_rdata_o[7:0] <= cpu_div_reg;
				PERIPH_GATE_OFS: reg_rdata_o[7:0] <= periph_gate_reg;
				PDIV0_OFS: reg_rdata_o[7:0] <= pdiv_reg[0];
				PDIV1_OFS: reg_rdata_o[7:0] <= pdiv_reg[1];
				PDIV2_OFS: reg_rdata_o[7:0] <= pdiv_reg[2];
				CLOCK_OUTPUT_FUNCTION_SEL_OFS: reg_rdata_o[2:0] <= clock_output_function_sel_reg;
				RUN_PWR_OFS: reg_rdata_o[1:0] <= run_power_config_reg;
				SLEEP_CFG_OFS: reg_rdata_o[4:0] <= sleep_cfg_reg;
				WAKE_EN_OFS: reg_rdata_o[5:0] <= wake_en_reg;
				STATUS_OFS: begin
					reg_rdata_o[2:0] <= state_reg;
					reg_rdata_o[ST_FRO_BIT] <= fro_on_o;
					reg_rdata_o[ST_LPOSC_BIT] <= lposc_on_o;
					reg_rdata_o[ST_BOD_BIT] <= brownout_detector_on_o;
					reg_rdata_o[ST_CAUSE_LSB +: NUM_WAKE] <= wake_cause_reg;
				end
				default: ;
			endcase
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

	// Free-running oscillator as a fractional enable of the core clock
	assign fro_sum = fro_acc_reg + fro_khz(fro_ctrl_reg[1:0]);

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fro_acc_reg <= 17'h00000;
			fro_tick_reg <= 1'b0;
		end else if (!fro_on_o) begin
			fro_acc_reg <= 17'h00000;
			fro_tick_reg <= 1'b0;
		end else if (fro_sum >= CORE_KHZ) begin
			fro_acc_reg <= fro_sum - CORE_KHZ;
			fro_tick_reg <= 1'b1;
		end else begin
			fro_acc_reg <= fro_sum;
			fro_tick_reg <= 1'b0;
		end
	end

	assign fro_out = fro_tick_reg & fro_out_en_o;

	// Fixed half rate of the oscillator
	cpm_clk_div u_fro_half (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.src_tick_i(fro_out & fro_ctrl_reg[FRO_HALF_BIT]),
		.div_i(FRO_HALF_DIV),
		.tick_o(fro_half_tick)
	);

	// Low-power oscillator runs only while enabled
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lposc_cnt_reg <= 7'h00;
			lposc_tick_reg <= 1'b0;
		end else if (!lposc_on_o) begin
			lposc_cnt_reg <= 7'h00;
			lposc_tick_reg <= 1'b0;
		end else if (lposc_cnt_reg == LPOSC_DIV_CYC - 7'h01) begin
			lposc_cnt_reg <= 7'h00;
			lposc_tick_reg <= 1'b1;
		end else begin
			lposc_cnt_reg <= lposc_cnt_reg + 7'h01;
			lposc_tick_reg <= 1'b0;
		end
	end

	// External clock edge, blocked until the pin matrix routes it
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ext_q_reg <= 1'b0;
		end else begin
			ext_q_reg <= external_clock_pin_i;
		end
	end

	// Rate at most 15 MHz keeps every edge visible here
	assign ext_tick = external_clock_pin_i & ~ext_q_reg
		& ext_clk_assigned_i & ~low_mode;

	// Main clock source selection
	cpm_src_mux u_main_mux (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.src_i({lposc_tick_reg, ext_tick, fro_half_tick, fro_out}),
		.sel_i(main_sel_reg),
		.tick_o(main_tick)
	);

	// Core clock divider
	cpm_clk_div u_cpu_div (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.src_tick_i(main_tick),
		.div_i(cpu_div_reg),
		.tick_o(cpu_tick)
	);

	// Clock output function source
	cpm_src_mux u_clock_output_function_mux (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.src_i({ext_tick, main_tick, lposc_tick_reg, fro_out}),
		.sel_i(clock_output_function_sel_reg),
		.tick_o(clock_output_function_tick)
	);

	// Dividers for peripherals 0 to 2 fed from the main clock
	for (genvar g = 0; g < NUM_PDIV; g++) begin : g_pdiv
		cpm_clk_div u_pdiv (
			.core_clk_i(core_clk_i),
			.rst_b_i(rst_b_i),
			.src_tick_i(main_tick),
			.div_i(pdiv_reg[g]),
			.tick_o(pdiv_tick[g])
		);
	end

	// Clock enables to core, bus and peripherals
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			core_clk_en_o <= 1'b0;
			main_clk_en_o <= 1'b0;
			clock_output_function_o <= 1'b0;
			lposc_clk_en_o <= 1'b0;
		end else begin
			core_clk_en_o <= cpu_tick && state_reg == ST_RUN;
			main_clk_en_o <= main_tick & ~low_mode;
			clock_output_function_o <= clock_output_function_tick;
			lposc_clk_en_o <= lposc_tick_reg;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			periph_clk_en_o <= 8'h00;
		end else begin
			for (int i = 0; i < NUM_PERIPH; i++) begin
				if (i < NUM_PDIV) begin
					periph_clk_en_o[i] <= pdiv_tick[i]
						& periph_gate_reg[i] & ~low_mode;
				end else begin
					periph_clk_en_o[i] <= main_tick
						& periph_gate_reg[i] & ~low_mode;
				end
			end
		end
	end

	// Qualified wake requests
	assign wake_hit = wake_irq_i & wake_en_reg & vector_en_i;
	assign low_mode = state_reg == ST_DEEP || state_reg == ST_PDOWN;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (sleep_req_i) begin
					case (sleep_cfg_reg[1:0])
						MODE_DEEP: state_next = ST_DEEP;
						MODE_PDOWN: state_next = ST_PDOWN;
						default: state_next = ST_SLEEP;
					endcase
				end
			end
			ST_SLEEP: begin
				if (irq_pending_i) begin
					state_next = ST_RUN;
				end
			end
			ST_DEEP, ST_PDOWN: begin
				if (wake_hit != 6'h00) begin
					state_next = ST_RESTORE;
				end
			end
			ST_RESTORE: begin
				if (settle_reg == SETTLE_CYC - 8'h01) begin
					state_next = ST_RUN;
				end
			end
			default: state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Sources settle before the core clock returns
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			settle_reg <= 8'h00;
		end else if (state_reg == ST_RESTORE) begin
			settle_reg <= settle_reg + 8'h01;
		end else begin
			settle_reg <= 8'h00;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wake_cause_reg <= 6'h00;
		end else if (low_mode && wake_hit != 6'h00) begin
			wake_cause_reg <= wake_hit;
		end
	end

	// Oscillator and detector power by mode
	always_comb begin
		fro_on_next = 1'b1;
		lposc_on_next = run_power_config_reg[RUN_LPOSC_BIT];
		bod_on_next = run_power_config_reg[RUN_BOD_BIT];
		case (state_next)
			ST_DEEP: begin
				fro_on_next = sleep_cfg_reg[SLP_KEEP_FRO_BIT];
				lposc_on_next = sleep_cfg_reg[SLP_KEEP_LPOSC_BIT];
				bod_on_next = sleep_cfg_reg[SLP_KEEP_BOD_BIT];
			end
			ST_PDOWN: begin
				fro_on_next = 1'b0;
				lposc_on_next = sleep_cfg_reg[SLP_KEEP_LPOSC_BIT];
				bod_on_next = sleep_cfg_reg[SLP_KEEP_BOD_BIT];
			end
			default: ;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fro_on_o <= 1'b1;
			fro_out_en_o <= 1'b1;
			lposc_on_o <= 1'b0;
			brownout_detector_on_o <= 1'b1;
			analog_on_o <= 1'b1;
			flash_on_o <= 1'b1;
			flash_standby_o <= 1'b0;
		end else begin
			fro_on_o <= fro_on_next;
			lposc_on_o <= lposc_on_next;
			brownout_detector_on_o <= bod_on_next;
			fro_out_en_o <= state_next != ST_DEEP
				&& state_next != ST_PDOWN;
			analog_on_o <= state_next != ST_DEEP
				&& state_next != ST_PDOWN;
			flash_on_o <= state_next != ST_PDOWN;
			flash_standby_o <= state_next == ST_DEEP;
		end
	end
endmodule // cpm_clock_power_ctrl
`default_nettype wire

// ### logic/cpm_src_mux.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_src_mux
	import cpm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Sources and selection
	input wire logic [3:0] src_i,
	input wire logic [2:0] sel_i,
	// Selected clock enable
	output logic tick_o
);
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tick_o <= 1'b0;
		end else if (sel_i >= SRC_NONE) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= src_i[sel_i[1:0]];
		end
	end
endmodule // cpm_src_mux
`default_nettype wire

// ### sim/clock_and_power_mode_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module clock_and_power_mode_control_test
	import cpm_pkg::*;
;
	logic clk, rst_b, wr_s, rd_s, go_sl, irq_c, s_req, irq_p, core_en, main_en;
	logic ext_pin, ext_asg, ext_run, cko, lpo_en, fro_on, fro_out, lpo_on, brownout_detector;
	logic ana, fl_on, fl_sb;
	logic [7:0] addr, pclk;
	logic [31:0] wd, rdat, rv;
	logic [5:0] wk, ven;
	logic [2:0] ediv;
	logic [6:0] mon;
	int err_count, num_checks, cyc, c;
	assign mon = {fl_sb, lpo_en, cko, pclk[7], pclk[0], core_en, main_en};
	cpm_clock_power_ctrl i_dut (.core_clk_i(clk), .rst_b_i(rst_b),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
		.reg_rdata_o(rdat), .sleep_req_i(s_req), .irq_pending_i(irq_p),
		.core_clk_en_o(core_en), .main_clk_en_o(main_en), .wake_irq_i(wk),
		.vector_en_i(ven), .external_clock_pin_i(ext_pin),
		.ext_clk_assigned_i(ext_asg), .clock_output_function_o(cko),
		.periph_clk_en_o(pclk), .lposc_clk_en_o(lpo_en), .fro_on_o(fro_on),
		.fro_out_en_o(fro_out), .lposc_on_o(lpo_on),
		.brownout_detector_on_o(brownout_detector), .analog_on_o(ana), .flash_on_o(fl_on),
		.flash_standby_o(fl_sb));
	cpm_core_model i_core (.core_clk_i(clk), .rst_b_i(rst_b),
		.go_sleep_i(go_sl), .irq_i(irq_c), .core_clk_en_i(core_en),
		.sleep_req_o(s_req), .irq_pending_o(irq_p));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// External source at 10 MHz, a rising edge every 10 cycles
	always @(posedge clk) begin
		ediv <= (ediv == 3'h4) ? 3'h0 : ediv + 3'h1;
		if (ediv == 3'h4 && ext_run) ext_pin <= ~ext_pin;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			$display("BAD %0t timeout", $time);
			err_count++;
			results();
		end
	end
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk_v(input logic [31:0] g, e, input string m);
		num_checks++;
		if (g !== e) begin
			$display("BAD %0t %s got %0h", $time, m, g);
			err_count++;
		end
	endtask
	task automatic chk_n(input int g, e, input string m);
		num_checks++;
		if (g < e - (e + 19) / 20 || g > e + (e + 19) / 20) begin
			$display("BAD %0t %s count %0d", $time, m, g);
			err_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk_v(rdat, e, "register read");
	endtask
	task automatic cnt(input int k, n);
		c = 0;
		// One edge lets ticks launched before the last write drain
		@(posedge clk);
		repeat (n) begin
			@(posedge clk);
			#1;
			if (mon[k] === 1'b1) c++;
		end
	endtask
	task automatic wait_on(input int k, input logic v, input int n);
		int t;
		t = 0;
		while (mon[k] !== v && t < n) begin
			@(posedge clk);
			#1;
			t++;
		end
		chk_v(32'(mon[k]), 32'(v), "wait for change");
	endtask
	task automatic pulse(input logic s);
		@(posedge clk);
		if (s) go_sl <= 1'b1;
		else irq_c <= 1'b1;
		@(posedge clk);
		go_sl <= 1'b0;
		irq_c <= 1'b0;
	endtask
	task automatic t_reset;
		rc(FRO_CTRL_OFS, 32'(FRO_CTRL_RST));
		rc(MAIN_SEL_OFS, 32'(SRC_FRO));
		rc(CPU_DIV_OFS, 32'(CPU_DIV_RST));
		rc(PERIPH_GATE_OFS, 32'(PERIPH_GATE_RST));
		rc(PDIV0_OFS, 32'(PDIV_RST));
		rc(CLOCK_OUTPUT_FUNCTION_SEL_OFS, 32'(SRC_NONE));
		rc(RUN_PWR_OFS, 32'(RUN_PWR_RST));
		rc(8'h30, 32'h00000000);
		cnt(0, 1000);
		chk_n(c, 120, "main at reset");
		$display("reset test done");
	endtask
	task automatic t_rates;
		int k[3] = '{150, 120, 90};
		for (int f = 0; f < 6; f++) begin
			wr(FRO_CTRL_OFS, {29'h0, f > 2, 2'(f % 3)});
			wr(MAIN_SEL_OFS, 32'(f > 2 ? SRC_FRO_HALF : SRC_FRO));
			cnt(0, 1000);
			chk_n(c, k[f % 3] / (f > 2 ? 2 : 1), "fro rate");
		end
		wr(FRO_CTRL_OFS, 32'(FRO_CTRL_RST) | 32'(1 << FRO_HALF_BIT));
		cnt(0, 1000);
		chk_n(c, 60, "fro half source");
		wr(FRO_CTRL_OFS, 32'(FRO_CTRL_RST));
		wr(MAIN_SEL_OFS, 32'(SRC_FRO));
		wr(CPU_DIV_OFS, 32'h00000002);
		cnt(1, 1000);
		chk_n(c, 60, "core divider");
		wr(CPU_DIV_OFS, 32'h00000000);
		cnt(1, 1000);
		chk_n(c, 0, "core divider zero");
		wr(CPU_DIV_OFS, 32'(CPU_DIV_RST));
		$display("rate test done");
	endtask
	task automatic t_gate;
		cnt(3, 500);
		chk_n(c, 0, "gated peripheral");
		wr(PERIPH_GATE_OFS, 32'h000000FF);
		wr(PDIV0_OFS, 32'h00000003);
		cnt(2, 1000);
		chk_n(c, 40, "peripheral divider");
		cnt(3, 1000);
		chk_n(c, 120, "open peripheral");
		wr(PERIPH_GATE_OFS, 32'h0000007F);
		cnt(3, 500);
		chk_n(c, 0, "single gate");
		$display("gate test done");
	endtask
	task automatic t_sources;
		logic [2:0] s[5] = '{OUT_FRO, OUT_LPOSC, OUT_MAIN, OUT_EXT, SRC_NONE};
		int e[5] = '{120, 10, 120, 0, 0};
		cnt(5, 500);
		chk_n(c, 0, "lposc disabled");
		wr(RUN_PWR_OFS, 32'h00000003);
		cnt(5, 1000);
		chk_n(c, 10, "lposc rate");
		for (int j = 0; j < 5; j++) begin
			wr(CLOCK_OUTPUT_FUNCTION_SEL_OFS, 32'(s[j]));
			cnt(4, 1000);
			chk_n(c, e[j], "clock output");
		end
		@(posedge clk);
		ext_asg <= 1'b1;
		wr(CLOCK_OUTPUT_FUNCTION_SEL_OFS, 32'(OUT_EXT));
		cnt(4, 1000);
		chk_n(c, 100, "ext on output");
		wr(MAIN_SEL_OFS, 32'(SRC_EXT));
		cnt(0, 1000);
		chk_n(c, 100, "ext main");
		@(posedge clk);
		ext_asg <= 1'b0;
		cnt(0, 500);
		chk_n(c, 0, "ext unassigned");
		wr(MAIN_SEL_OFS, 32'(SRC_LPOSC));
		cnt(0, 1000);
		chk_n(c, 10, "lposc main");
		wr(MAIN_SEL_OFS, 32'(SRC_NONE));
		cnt(0, 500);
		chk_n(c, 0, "main tied off");
		wr(MAIN_SEL_OFS, 32'(SRC_FRO));
		$display("source test done");
	endtask
	task automatic t_sleep;
		wr(SLEEP_CFG_OFS, 32'(MODE_SLEEP));
		pulse(1'b1);
		repeat (3) @(posedge clk);
		cnt(1, 100);
		chk_n(c, 0, "core in sleep");
		cnt(2, 500);
		chk_n(c, 20, "peripheral in sleep");
		pulse(1'b0);
		wait_on(1, 1'b1, 30);
		$display("sleep test done");
	endtask
	task automatic t_deep;
		wr(SLEEP_CFG_OFS, 32'h00000019);
		wr(WAKE_EN_OFS, 32'h00000000);
		pulse(1'b1);
		wait_on(6, 1'b1, 10);
		chk_v({fro_on, fro_out, ana, fl_on, lpo_on, brownout_detector}, 6'h07, "deep");
		@(posedge clk);
		wk <= 6'h01;
		ven <= 6'h01;
		cnt(6, 20);
		chk_n(c, 20, "wake without system enable");
		@(posedge clk);
		ven <= 6'h00;
		wr(WAKE_EN_OFS, 32'h0000003F);
		cnt(6, 20);
		chk_n(c, 20, "wake without vector enable");
		for (int i = 0; i < NUM_WAKE; i++) begin
			if (i > 0) begin
				pulse(1'b1);
				wait_on(6, 1'b1, 10);
			end
			@(posedge clk);
			wk <= 6'(1 << i);
			ven <= 6'h3F;
			wait_on(6, 1'b0, 5);
			chk_v({fro_on, fro_out, ana, fl_on}, 4'hF, "sources back");
			cnt(1, 18);
			chk_n(c, 0, "core during settle");
			wait_on(1, 1'b1, 40);
			@(posedge clk);
			wk <= 6'h00;
		end
		rc(STATUS_OFS, 32'h00002070);
		$display("deep-sleep test done");
	endtask
	task automatic t_pdown;
		wr(SLEEP_CFG_OFS, 32'h0000000A);
		pulse(1'b1);
		repeat (5) @(posedge clk);
		chk_v({fro_on, fro_out, ana, fl_on, lpo_on, brownout_detector}, 6'h02, "pdown");
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		chk_v({fro_on, fro_out, fl_on, lpo_on}, 4'hE, "reset wake");
		rc(MAIN_SEL_OFS, 32'(SRC_FRO));
		rc(SLEEP_CFG_OFS, 32'(SLEEP_CFG_RST));
		$display("power-down test done");
	endtask
	initial begin
		{rst_b, wr_s, rd_s, go_sl, irq_c, ext_pin, ext_asg} = 7'h00;
		{addr, wd, wk, ven, ediv, cyc, err_count, num_checks} = '0;
		ext_run = 1'b1;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_rates();
		t_gate();
		t_sources();
		t_sleep();
		t_deep();
		t_pdown();
		results();
	end
endmodule // clock_and_power_mode_control_test
`default_nettype wire

// ### sim/cpm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_core_model (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Bench commands
	input wire logic go_sleep_i,
	input wire logic irq_i,
	// Controller side
	input wire logic core_clk_en_i,
	output logic sleep_req_o,
	output logic irq_pending_o
);
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sleep_req_o <= 1'b0;
		end else begin
			sleep_req_o <= go_sleep_i;
		end
	end
	// Interrupt stays pending until the core has run again
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_pending_o <= 1'b0;
		end else if (irq_i) begin
			irq_pending_o <= 1'b1;
		end else if (core_clk_en_i) begin
			irq_pending_o <= 1'b0;
		end
	end
endmodule // cpm_core_model
`default_nettype wire

// ### sim/cpm_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_ctrl_props
	import cpm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Watched ports
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic [5:0] wake_irq_i,
	input wire logic [5:0] vector_en_i,
	input wire logic core_clk_en_o,
	input wire logic main_clk_en_o,
	input wire logic lposc_clk_en_o,
	input wire logic fro_on_o,
	input wire logic fro_out_en_o,
	input wire logic lposc_on_o,
	input wire logic analog_on_o,
	input wire logic flash_on_o,
	input wire logic flash_standby_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	chk_rst_fro: assert property ($rose(rst_b_i) |-> fro_on_o && fro_out_en_o && !lposc_on_o)
		else $error("oscillator not running after reset");
	chk_lposc_gate: assert property (!lposc_on_o [*3] |-> !lposc_clk_en_o)
		else $error("low-power tick while oscillator off");
	chk_deep_levels: assert property (flash_standby_o |-> !fro_out_en_o && !analog_on_o)
		else $error("deep-sleep levels wrong");
	chk_pdown_off: assert property (!flash_on_o |-> !fro_on_o && !analog_on_o)
		else $error("power-down left a source on");
	chk_deep_core: assert property ($rose(flash_standby_o) |-> ##2 !core_clk_en_o [*4])
		else $error("core ticks in deep-sleep");
	chk_main_deep: assert property (flash_standby_o [*3] |-> !main_clk_en_o)
		else $error("main clock runs in deep-sleep");
	chk_restore_hold: assert property ($fell(flash_standby_o) |-> !core_clk_en_o [*8])
		else $error("core clock back before sources settle");
	chk_wake_qual: assert property (flash_standby_o && !(|(wake_irq_i & vector_en_i)) |=> flash_standby_o)
		else $error("wake without enable");
	chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h00000000)
		else $error("read data outside read cycle");
	cov_deep: cover property ($rose(flash_standby_o));
	cov_pdown: cover property ($fell(flash_on_o));
	cov_lposc: cover property (lposc_clk_en_o);
endmodule // cpm_ctrl_props
bind cpm_clock_power_ctrl cpm_ctrl_props i_props (.core_clk_i, .rst_b_i,
	.reg_rd_i, .reg_rdata_o, .wake_irq_i, .vector_en_i, .core_clk_en_o,
	.main_clk_en_o, .lposc_clk_en_o, .fro_on_o, .fro_out_en_o, .lposc_on_o,
	.analog_on_o, .flash_on_o, .flash_standby_o);
`default_nettype wire
